/* File: shared/csd_pkg.sv */
package csd_pkg;
   // Configuration offsets (byte addresses and dword indices within config space)
   localparam logic [7:0] CSD_OFS_DEVCTL = 8'h90;
   localparam logic [7:0] CSD_OFS_DIAG = 8'h93;
   localparam logic [7:0] CSD_OFS_DMA0 = 8'h94;
   localparam logic [7:0] CSD_OFS_DMA1 = 8'h98;
   localparam logic [5:0] CSD_DW_DIAG = 6'h24;
   localparam logic [5:0] CSD_DW_DMA0 = 6'h25;
   localparam logic [5:0] CSD_DW_DMA1 = 6'h26;
   localparam logic [5:0] CSD_DW_ID = 6'h00;
   localparam int CSD_DIAG_LANE = 3;
   // Diagnostic register fields
   localparam logic [7:0] CSD_DIAG_RST = 8'h61;
   localparam int CSD_DG_IDMASK = 7;
   localparam int CSD_DG_ROUTE = 5;
   localparam int CSD_DG_DTDIS = 4;
   localparam int CSD_DG_REXT = 3;
   localparam int CSD_DG_CBTIM = 2;
   localparam int CSD_DG_PCITIM = 1;
   localparam int CSD_DG_ASYNC = 0;
   localparam logic [7:0] CSD_DIAG_SHARED = 8'h9f;
   // Socket DMA register fields
   localparam logic [31:0] CSD_DMA0_RST = 32'h0000_0000;
   localparam logic [31:0] CSD_DMA1_RST = 32'h0000_0000;
   localparam logic [31:0] CSD_DMA0_WMASK = 32'h0000_0003;
   localparam logic [31:0] CSD_DMA1_WMASK = 32'h0000_fff7;
   localparam int CSD_D1_EN = 0;
   localparam int CSD_D1_EXT = 3;
   localparam logic [1:0] CSD_PIN_NONE = 2'h0;
   localparam logic [1:0] CSD_PIN_SPKR = 2'h1;
   localparam logic [1:0] CSD_PIN_IOIS16 = 2'h2;
   localparam logic [1:0] CSD_PIN_INPACK = 2'h3;
   localparam logic [1:0] CSD_XW_8 = 2'h0;
   localparam logic [1:0] CSD_XW_16 = 2'h1;
   // Retry and discard timing, in clocks
   localparam logic [6:0] CSD_RETRY_SHORT = 7'h10;
   localparam logic [6:0] CSD_RETRY_LONG = 7'h40;
   localparam int CSD_DISC_SHORT_LOG2 = 10;
   localparam int CSD_DISC_LONG_LOG2 = 15;
   localparam logic [15:0] CSD_DISC_SHORT = 16'h0400;
   localparam logic [15:0] CSD_DISC_LONG = 16'h8000;
   localparam logic [31:0] CSD_ONES = 32'hffff_ffff;
   // Compatibility register bits used for routing
   localparam int CSD_C803_BIT = 4;
   localparam logic [3:0] CSD_C805_ROUTE = 4'h0;
endpackage

/* File: hw/csd_sock_regs.sv */
module csd_sock_regs
   import csd_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Write port
   input wire logic wr_dma0,
   input wire logic wr_dma1,
   input wire logic [31:0] wdata,
   input wire logic [3:0] be,
   // Register contents
   output logic [31:0] dma0_r,
   output logic [31:0] dma1_r
);
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] b, input logic [31:0] m);
      logic [31:0] lanes;
      lanes = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & m;
      merge = (old & ~lanes) | (nw & lanes);
   endfunction

   // Masks keep reserved and extended-addressing bits at zero
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dma0_r <= CSD_DMA0_RST;
      end else if (wr_dma0) begin
         dma0_r <= merge(dma0_r, wdata, be, CSD_DMA0_WMASK);
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dma1_r <= CSD_DMA1_RST;
      end else if (wr_dma1) begin
         dma1_r <= merge(dma1_r, wdata, be, CSD_DMA1_WMASK);
      end
   end
endmodule

/* File: hw/csd_disc_timer.sv */
module csd_disc_timer
   import csd_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Control
   input wire logic start,
   input wire logic stop,
   input wire logic short_sel,
   // Status
   output logic expired_r
);
   logic [15:0] cnt_r;
   logic run_r;
   logic [15:0] limit;

   assign limit = short_sel ? CSD_DISC_SHORT : CSD_DISC_LONG;

   // Length is sampled live so a select change also applies to a running timer
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 16'h0000;
         run_r <= 1'b0;
         expired_r <= 1'b0;
      end else begin
         expired_r <= 1'b0;
         if (stop) begin
            run_r <= 1'b0;
            cnt_r <= 16'h0000;
         end else if (start) begin
            run_r <= 1'b1;
            cnt_r <= 16'h0001;
         end else if (run_r) begin
            if (cnt_r >= limit) begin
               run_r <= 1'b0;
               expired_r <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 16'h0001;
            end
         end
      end
   end
endmodule

/* File: hw/csd_cfg_top.sv */
module csd_cfg_top
   import csd_pkg::*;
#(
   parameter logic [15:0] VENDOR_ID = 16'h1234,  // Arbitrary value
   parameter logic [15:0] DEVICE_ID = 16'h5678   // Arbitrary value
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Configuration access
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic cfg_func,
   input wire logic [5:0] cfg_dword,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata_r,
   output logic cfg_rvalid_r,
   // Compatibility register inputs, per socket
   input wire logic [1:0] compat803_b4,
   input wire logic [7:0] compat805_hi,
   input wire logic [1:0] status_change_evt,
   // I/O space decode
   input wire logic io_cmd,
   input wire logic [31:0] io_addr,
   output logic [1:0] io_hit_r,
   // Card DMA interface
   input wire logic [1:0] pin_spkr,
   input wire logic [1:0] pin_iois16,
   input wire logic [1:0] pin_inpack,
   output logic [1:0] dma_req_r,
   output logic [1:0] card_xfer16_r,
   // Card data path split of a prefetched host word
   input wire logic [1:0] word_load,
   input wire logic [31:0] word_in,
   input wire logic [1:0] half_take,
   output logic [31:0] card_half_r,
   output logic [1:0] half_valid_r,
   // Delayed transaction controls
   input wire logic dt_start_pci,
   input wire logic dt_done_pci,
   input wire logic dt_start_cb,
   input wire logic dt_done_cb,
   output logic delayed_txn_enable_r,
   output logic [6:0] retry_limit_r,
   output logic pci_discard_r,
   output logic card_discard_r,
   // Status change interrupt routing
   output logic [1:0] card_status_change_pci_r,
   output logic [1:0] card_status_change_async_r
);
   import csd_pkg::*;

   logic [7:0] diag_r;
   logic [31:0] dma0_s [2];
   logic [31:0] dma1_s [2];
   logic [31:0] rd_nxt;
   logic wr_diag;
   logic pci_exp;
   logic cb_exp;

   function automatic logic win_hit(input logic [31:0] d1,
      input logic [31:0] a);
      win_hit = d1[CSD_D1_EN] && (a[31:16] == 16'h0000)
         && (a[15:4] == d1[15:4]);
   endfunction

   function automatic logic pin_pick(input logic [1:0] sel,
      input logic s, input logic i, input logic p);
      case (sel)
         CSD_PIN_SPKR: pin_pick = s;
         CSD_PIN_IOIS16: pin_pick = i;
         CSD_PIN_INPACK: pin_pick = p;
         default: pin_pick = 1'b0;
      endcase
   endfunction

   // Shared bits only written through function 0; bit 5 and 6 likewise
   // kept single, since a per-function copy has no consumer here
   assign wr_diag = cfg_wr && !cfg_func && (cfg_dword == CSD_DW_DIAG)
      && cfg_be[CSD_DIAG_LANE];

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         diag_r <= CSD_DIAG_RST;
      end else if (wr_diag) begin
         diag_r <= cfg_wdata[CSD_DIAG_LANE*8 +: 8];
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sock
         csd_sock_regs u_regs (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .wr_dma0(cfg_wr && (cfg_func == 1'(g))
               && (cfg_dword == CSD_DW_DMA0)),
            .wr_dma1(cfg_wr && (cfg_func == 1'(g))
               && (cfg_dword == CSD_DW_DMA1)),
            .wdata(cfg_wdata),
            .be(cfg_be),
            .dma0_r(dma0_s[g]),
            .dma1_r(dma1_s[g])
         );
      end
   endgenerate

   // Read mux
   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (cfg_dword)
         CSD_DW_ID: begin
            if (diag_r[CSD_DG_IDMASK]) begin
               rd_nxt = CSD_ONES;
            end else begin
               rd_nxt = {DEVICE_ID, VENDOR_ID};
            end
         end
         CSD_DW_DIAG: rd_nxt = {diag_r, 24'h000000};
         CSD_DW_DMA0: rd_nxt = dma0_s[cfg_func] & CSD_DMA0_WMASK;
         CSD_DW_DMA1: rd_nxt = dma1_s[cfg_func] & CSD_DMA1_WMASK;
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cfg_rdata_r <= 32'h0000_0000;
         cfg_rvalid_r <= 1'b0;
      end else begin
         cfg_rvalid_r <= cfg_rd;
         if (cfg_rd) begin
            cfg_rdata_r <= rd_nxt;
         end
      end
   end

   // Window decode: upper half must be zero, low nibble ignored
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         io_hit_r <= 2'b00;
      end else begin
         for (int s = 0; s < 2; s++) begin
            io_hit_r[s] <= io_cmd && win_hit(dma1_s[s], io_addr);
         end
      end
   end

   // Request pin and width per socket
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dma_req_r <= 2'b00;
         card_xfer16_r <= 2'b00;
      end else begin
         for (int s = 0; s < 2; s++) begin
            dma_req_r[s] <= pin_pick(dma0_s[s][1:0], pin_spkr[s],
               pin_iois16[s], pin_inpack[s]);
            card_xfer16_r[s] <= (dma1_s[s][2:1] == CSD_XW_16);
         end
      end
   end

   // Host word is held and handed out as two halves, low half first;
   // only one socket's word is held at a time, socket 0 wins a tie
   logic [15:0] hi_half_r;
   logic hi_pend_r;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         card_half_r <= 32'h0000_0000;
         half_valid_r <= 2'b00;
         hi_half_r <= 16'h0000;
         hi_pend_r <= 1'b0;
      end else begin
         if (|(half_take & half_valid_r)) begin
            if (hi_pend_r) begin
               card_half_r <= {16'h0000, hi_half_r};
               hi_pend_r <= 1'b0;
            end else begin
               half_valid_r <= 2'b00;
            end
         end else if (!(|half_valid_r) && (|word_load)) begin
            half_valid_r <= word_load[0] ? 2'b01 : 2'b10;
            card_half_r <= {16'h0000, word_in[15:0]};
            hi_half_r <= word_in[31:16];
            hi_pend_r <= 1'b1;
         end
      end
   end

   csd_disc_timer u_pci_tim (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .start(dt_start_pci && !diag_r[CSD_DG_DTDIS]),
      .stop(dt_done_pci || diag_r[CSD_DG_DTDIS]),
      .short_sel(diag_r[CSD_DG_PCITIM]),
      .expired_r(pci_exp)
   );

   csd_disc_timer u_cb_tim (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .start(dt_start_cb),
      .stop(dt_done_cb),
      .short_sel(diag_r[CSD_DG_CBTIM]),
      .expired_r(cb_exp)
   );

   // Delayed transaction controls
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         delayed_txn_enable_r <= 1'b1;
         retry_limit_r <= CSD_RETRY_SHORT;
         pci_discard_r <= 1'b0;
         card_discard_r <= 1'b0;
      end else begin
         delayed_txn_enable_r <= !diag_r[CSD_DG_DTDIS];
         retry_limit_r <= diag_r[CSD_DG_REXT] ? CSD_RETRY_LONG
            : CSD_RETRY_SHORT;
         pci_discard_r <= pci_exp;
         card_discard_r <= cb_exp;
      end
   end

   // Status change routing and async generation
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         card_status_change_pci_r <= 2'b00;
         card_status_change_async_r <= 2'b00;
      end else begin
         for (int s = 0; s < 2; s++) begin
            if (diag_r[CSD_DG_ROUTE]) begin
               card_status_change_pci_r[s] <= status_change_evt[s]
                  && (compat805_hi[s*4 +: 4] == CSD_C805_ROUTE);
            end else begin
               card_status_change_pci_r[s] <= status_change_evt[s]
                  && compat803_b4[s];
            end
            card_status_change_async_r[s] <= status_change_evt[s]
               && diag_r[CSD_DG_ASYNC];
         end
      end
   end
endmodule

/* File: verification/csd_cfg_properties.sv */
module csd_cfg_chk
   import csd_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Config bus
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic cfg_func,
   input wire logic [5:0] cfg_dword,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   input wire logic cfg_rvalid_r,
   // Status change
   input wire logic [1:0] status_change_evt,
   input wire logic [1:0] card_status_change_pci_r,
   input wire logic [1:0] card_status_change_async_r,
   // Delayed transactions
   input wire logic dt_start_pci,
   input wire logic pci_discard_r,
   input wire logic delayed_txn_enable_r,
   input wire logic [6:0] retry_limit_r,
   // Word split
   input wire logic [1:0] word_load,
   input wire logic [31:0] word_in,
   input wire logic [1:0] half_take,
   input wire logic [1:0] half_valid_r,
   input wire logic [31:0] card_half_r
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] age_r;
   wire diag0 = cfg_wr && !cfg_func && cfg_dword == CSD_DW_DIAG && cfg_be[3];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // Saturates so a very late expiry still counts as late enough
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         age_r <= 16'h0;
      end else if (dt_start_pci) begin
         age_r <= 16'h0;
      end else if (age_r != 16'hffff) begin
         age_r <= age_r + 16'h1;
      end
   end
   chk_read_answer: assert property (
      cfg_rvalid_r == $past(cfg_rd)) else $error("read answer timing");
   chk_dt_disable: assert property (diag0 |-> ##2
      delayed_txn_enable_r == !$past(cfg_wdata[28], 2))
      else $error("delayed transaction enable wrong");
   chk_retry_latency_extend: assert property (diag0 |-> ##2
      retry_limit_r == ($past(cfg_wdata[27], 2) ? CSD_RETRY_LONG
      : CSD_RETRY_SHORT)) else $error("retry limit wrong");
   chk_func1_ignored: assert property (
      cfg_wr && cfg_func && cfg_dword == CSD_DW_DIAG |=>
      ($stable(retry_limit_r) && $stable(delayed_txn_enable_r))[*2])
      else $error("function 1 changed shared bits");
   chk_async_cause: assert property (|card_status_change_async_r |->
      (card_status_change_async_r & ~$past(status_change_evt)) == 2'h0)
      else $error("async event without cause");
   chk_route_cause: assert property (|card_status_change_pci_r |->
      (card_status_change_pci_r & ~$past(status_change_evt)) == 2'h0)
      else $error("routed event without cause");
   chk_discard_late: assert property (pci_discard_r |->
      age_r >= 16'h03ff ##1 !pci_discard_r)
      else $error("host discard too early or too long");
   chk_half_load: assert property (word_load == 2'h1 &&
      half_valid_r == 2'h0 |=> $onehot0(half_valid_r) && half_valid_r[0]
      && card_half_r[15:0] == $past(word_in[15:0]))
      else $error("low half not presented");
   cover property (pci_discard_r);
   cover property (half_valid_r[0] && half_take[0]);
   cover property (diag0);
endmodule

/* File: verification/csd_host_model.sv */
module csd_host_model (
   // Clock
   input wire logic clk_sys,
   // Requests
   output logic cfg_rd,
   output logic cfg_wr,
   output logic cfg_func,
   output logic [5:0] cfg_dword,
   output logic [3:0] cfg_be,
   output logic [31:0] cfg_wdata,
   // Answer
   input wire logic [31:0] cfg_rdata_r,
   input wire logic cfg_rvalid_r
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cfg_rd = 1'b0;
      cfg_wr = 1'b0;
      cfg_func = 1'b0;
      cfg_dword = 6'h0;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0;
   end
   task automatic wr(input logic f, input logic [5:0] dw,
         input logic [3:0] b, input logic [31:0] d);
      @(posedge clk_sys);
      cfg_wr <= 1'b1;
      cfg_func <= f;
      cfg_dword <= dw;
      cfg_be <= b;
      cfg_wdata <= d;
      @(posedge clk_sys);
      cfg_wr <= 1'b0;
      // Released data flips so a stale value cannot pass for a fresh one
      cfg_wdata <= ~d;
   endtask
   task automatic rd(input logic f, input logic [5:0] dw,
         output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys);
      cfg_rd <= 1'b1;
      cfg_func <= f;
      cfg_dword <= dw;
      @(posedge clk_sys);
      cfg_rd <= 1'b0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (cfg_rvalid_r !== 1'b1 && n < 4);
      q = cfg_rdata_r;
   endtask
endmodule

/* File: verification/csd_cfg_top_tb.sv */
module csd_cfg_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import csd_pkg::*;
   localparam logic [15:0] VID = 16'h0a5c; // Arbitrary value
   localparam logic [15:0] DID = 16'h3c96; // Arbitrary value
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic cfg_rd, cfg_wr, cfg_func, cfg_rvalid_r, io_cmd;
   logic dt_start_pci, dt_done_pci, dt_start_cb, dt_done_cb;
   logic delayed_txn_enable_r, pci_discard_r, card_discard_r;
   logic [5:0] cfg_dword;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata_r, word_in, io_addr, card_half_r, rd_q;
   logic [1:0] compat803_b4, status_change_evt, word_load, half_take;
   logic [1:0] pin_spkr, pin_iois16, pin_inpack, io_hit_r, dma_req_r;
   logic [1:0] card_xfer16_r, half_valid_r;
   logic [1:0] card_status_change_pci_r, card_status_change_async_r;
   logic [7:0] compat805_hi;
   logic [6:0] retry_limit_r;
   int miscompares = 0;
   int num_checks = 0;
   int n;
   always #12.5 clk_sys = ~clk_sys;
   csd_host_model csd_host_model_i (.*);
   csd_cfg_top #(.VENDOR_ID(VID), .DEVICE_ID(DID)) csd_cfg_top_i (.*);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      if (miscompares == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
   endtask
   task automatic wr(input logic f, input logic [5:0] d, input logic [3:0] b,
         input logic [31:0] v);
      csd_host_model_i.wr(f, d, b, v);
   endtask
   task automatic rd(input logic f, input logic [5:0] d);
      csd_host_model_i.rd(f, d, rd_q);
   endtask
   task automatic take_half;
      half_take <= 2'h1;
      tick(1);
      half_take <= 2'h0;
      tick(1);
   endtask
   initial begin
      tick(40000);
      miscompares++;
      print_verdict;
   end
   initial begin
      {io_cmd, dt_start_pci, dt_done_pci, dt_start_cb, dt_done_cb} = 5'h0;
      {compat803_b4, status_change_evt, word_load, half_take} = 8'h0;
      {pin_spkr, pin_iois16, pin_inpack, compat805_hi} = 14'h0;
      io_addr = 32'h0;
      word_in = 32'h0;
      tick(6);
      rstn <= 1'b1;
      check(delayed_txn_enable_r, 32'h1);
      check(retry_limit_r, 32'h10);
      rd(0, CSD_DW_DIAG);
      check(rd_q[31:24], CSD_DIAG_RST);
      for (int k = 0; k < 4; k++) begin
         rd(k[0], k[1] ? CSD_DW_DMA1 : CSD_DW_DMA0);
         check(rd_q, 32'h0);
      end
      rd(0, CSD_DW_ID);
      check(rd_q, {DID, VID});
      wr(0, CSD_DW_DIAG, 4'h8, 32'he100_0000);
      rd(0, CSD_DW_ID);
      check(rd_q, CSD_ONES);
      wr(0, CSD_DW_DIAG, 4'h8, 32'h7900_0000);
      tick(2);
      check(delayed_txn_enable_r, 32'h0);
      check(retry_limit_r, CSD_RETRY_LONG);
      rd(0, CSD_DW_ID);
      check(rd_q, {DID, VID});
      wr(1, CSD_DW_DIAG, 4'h8, 32'h6100_0000);
      wr(0, CSD_DW_DIAG, 4'h7, 32'h6100_0000);
      rd(0, CSD_DW_DIAG);
      check(rd_q[31:24], 32'h79);
      // Socket 0 raises only the chosen pin, and no request when none is chosen
      for (int c = 0; c < 4; c++) begin
         wr(0, CSD_DW_DMA0, 4'hf, {30'h3fff_ffff, c[1:0]});
         pin_spkr <= {1'b1, c == 1 || c == 0};
         pin_iois16 <= {1'b1, c == 2 || c == 0};
         pin_inpack <= {1'b1, c == 3 || c == 0};
         rd(0, CSD_DW_DMA0);
         check(rd_q, {30'h0, c[1:0]});
         check(dma_req_r, {1'b0, c != 0});
      end
      io_cmd <= 1'b1;
      io_addr <= 32'h0000_ab37;
      wr(1, CSD_DW_DMA1, 4'hf, 32'hffff_ab3b);
      rd(1, CSD_DW_DMA1);
      check(rd_q, 32'h0000_ab33);
      check(card_xfer16_r, 32'h2);
      check(io_hit_r, 32'h2);
      io_addr <= 32'h0001_ab37;
      tick(2);
      check(io_hit_r, 32'h0);
      io_addr <= 32'h0000_ab37;
      wr(1, CSD_DW_DMA1, 4'hf, 32'h0000_ab34);
      tick(2);
      check(io_hit_r, 32'h0);
      check(card_xfer16_r, 32'h0);
      rd(0, CSD_DW_DMA1);
      check(rd_q, 32'h0);
      compat805_hi <= 8'h50;
      compat803_b4 <= 2'h2;
      status_change_evt <= 2'h3;
      tick(2);
      check(card_status_change_pci_r, 32'h1);
      check(card_status_change_async_r, 32'h3);
      wr(0, CSD_DW_DIAG, 4'h8, 32'h4000_0000);
      tick(2);
      check(card_status_change_pci_r, 32'h2);
      check(card_status_change_async_r, 32'h0);
      status_change_evt <= 2'h0;
      word_in <= 32'h1234_5678;
      word_load <= 2'h1;
      tick(1);
      word_load <= 2'h0;
      word_in <= 32'hedcb_a987;
      tick(1);
      check(half_valid_r, 32'h1);
      check(card_half_r[15:0], 32'h5678);
      take_half;
      check(half_valid_r, 32'h1);
      check(card_half_r[15:0], 32'h1234);
      take_half;
      check(half_valid_r, 32'h0);
      wr(0, CSD_DW_DIAG, 4'h8, 32'h6700_0000);
      for (int k = 0; k < 4; k++) begin
         if (k == 2) begin
            wr(0, CSD_DW_DIAG, 4'h8, 32'h7700_0000);
         end else if (k == 3) begin
            wr(0, CSD_DW_DIAG, 4'h8, 32'h6100_0000);
         end
         dt_start_pci <= (k != 1);
         dt_start_cb <= (k == 1);
         tick(1);
         {dt_start_pci, dt_start_cb} <= 2'h0;
         n = 1;
         while ((k == 1 ? card_discard_r : pci_discard_r) !== 1'b1
               && n < (k == 3 ? 33000 : 1100)) begin
            tick(1);
            n++;
         end
         if (k == 3) begin
            check(n > 32760 && n < 32780, 1);
         end else begin
            check(k == 2 ? n == 1100 : n > 1020 && n < 1032, 1);
         end
      end
      print_verdict;
   end
endmodule
bind csd_cfg_top csd_cfg_chk csd_cfg_chk_i (.*);
